// ===== pkg/gcu_pkg.sv
// Shared constants, types and register map of the general capture/compare unit
package gcu_pkg;
    // ------------------------------------------------------------
    // Sizes
    // ------------------------------------------------------------
    localparam int GCU_CHANNELS = 16;
    localparam int GCU_TMR_W = 16;
    localparam int GCU_ADDR_W = 8;
    localparam int GCU_DATA_W = 32;
    localparam int GCU_CTRL_W = 8;
    // ------------------------------------------------------------
    // Register map (byte addresses)
    // ------------------------------------------------------------
    localparam logic [1:0] GCU_RGN_CTRL = 2'h0;
    localparam logic [1:0] GCU_RGN_VALUE = 2'h1;
    localparam logic [GCU_ADDR_W-1:0] GCU_PIN_OFF = 8'h80;
    localparam int GCU_RGN_MSB = 7;
    localparam int GCU_RGN_LSB = 6;
    localparam int GCU_IDX_MSB = 5;
    localparam int GCU_IDX_LSB = 2;
    // ------------------------------------------------------------
    // Bus answers
    // ------------------------------------------------------------
    localparam logic [1:0] GCU_RESP_OKAY = 2'h0;
    localparam logic [1:0] GCU_RESP_SLVERR = 2'h2;
    // ------------------------------------------------------------
    // Channel control word
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        GCU_MODE_OFF,
        GCU_MODE_CAPTURE,
        GCU_MODE_CMP_IRQ,
        GCU_MODE_CMP_SETCLR,
        GCU_MODE_DOUBLE
    } gcu_mode_e;
    typedef struct packed {
        logic done;
        logic single;
        logic tsel;
        logic [1:0] edge_sel;
        gcu_mode_e mode;
    } gcu_ctrl_s;
    localparam logic [GCU_CTRL_W-1:0] GCU_CTRL_WMASK = 8'h7F;
    localparam int GCU_EDGE_RISE_BIT = 0;
    localparam int GCU_EDGE_FALL_BIT = 1;
    // ------------------------------------------------------------
    // Timer carrier and module state
    // ------------------------------------------------------------
    typedef struct packed {
        logic [GCU_TMR_W-1:0] count;
        logic upd;
        logic ovf;
    } gcu_timer_s;
    typedef struct packed {
        logic aw_got;
        logic w_got;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [1:0] rresp;
        logic [GCU_DATA_W-1:0] rdata;
        logic [GCU_ADDR_W-1:0] awaddr;
        logic [GCU_DATA_W-1:0] wdata;
        logic [3:0] wstrb;
        gcu_ctrl_s [GCU_CHANNELS-1:0] ctrl;
        logic [GCU_CHANNELS-1:0][GCU_TMR_W-1:0] value;
        logic [GCU_CHANNELS-1:0] fired;
        logic [GCU_CHANNELS-1:0] pin;
        logic [GCU_CHANNELS-1:0] irq;
    } gcu_state_s;
    typedef struct packed {
        logic [GCU_CHANNELS-1:0] s1;
        logic [GCU_CHANNELS-1:0] s2;
        logic [GCU_CHANNELS-1:0] s3;
        logic [GCU_CHANNELS-1:0] rise;
        logic [GCU_CHANNELS-1:0] fall;
    } gcu_sync_s;
endpackage : gcu_pkg

// ===== rtl/gcu_pin_sync.sv
// Pin synchroniser and edge detector for the capture inputs
`timescale 1ns/10ps
module gcu_pin_sync (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic [gcu_pkg::GCU_CHANNELS-1:0] pin_in,
    output logic [gcu_pkg::GCU_CHANNELS-1:0] rise,
    output logic [gcu_pkg::GCU_CHANNELS-1:0] fall
);
    gcu_pkg::gcu_sync_s st_reg;
    gcu_pkg::gcu_sync_s st_next;

    // ------------------------------------------------------------
    // Two flops, then edge compare on settled stages only
    // ------------------------------------------------------------
    always_comb begin
        st_next = st_reg;
        st_next.s1 = pin_in;
        st_next.s2 = st_reg.s1;
        st_next.s3 = st_reg.s2;
        st_next.rise = st_reg.s2 & ~st_reg.s3;
        st_next.fall = ~st_reg.s2 & st_reg.s3;
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign rise = st_reg.rise;
    assign fall = st_reg.fall;

    single_rise_a: assert property (@(posedge clk_sys) disable iff (rst) rise[0] |=> !rise[0])
        else $error("one transition gave two rising events");
endmodule : gcu_pin_sync

// ===== rtl/gcu_capcom.sv
// Sixteen-channel capture/compare unit with AXI4-Lite register access
`timescale 1ns/10ps
module gcu_capcom (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic [gcu_pkg::GCU_ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [gcu_pkg::GCU_DATA_W-1:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [gcu_pkg::GCU_ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [gcu_pkg::GCU_DATA_W-1:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire gcu_pkg::gcu_timer_s tmr_a,
    input wire gcu_pkg::gcu_timer_s tmr_b,
    input wire logic [gcu_pkg::GCU_CHANNELS-1:0] pin_in,
    output logic [gcu_pkg::GCU_CHANNELS-1:0] pin_out,
    output logic [gcu_pkg::GCU_CHANNELS-1:0] pin_oe,
    output logic [gcu_pkg::GCU_CHANNELS-1:0] chan_irq
);
    gcu_pkg::gcu_state_s st_reg;
    gcu_pkg::gcu_state_s st_next;
    logic [gcu_pkg::GCU_CHANNELS-1:0] rise;
    logic [gcu_pkg::GCU_CHANNELS-1:0] fall;
    logic [gcu_pkg::GCU_CHANNELS-1:0] hit;
    logic [gcu_pkg::GCU_CHANNELS-1:0] ovf;
    logic [gcu_pkg::GCU_CHANNELS-1:0] capt;
    logic [gcu_pkg::GCU_CHANNELS-1:0] wr_ctrl;
    logic [gcu_pkg::GCU_TMR_W-1:0] cur_cnt [gcu_pkg::GCU_CHANNELS];
    logic wr_go;

    // ------------------------------------------------------------
    // Byte-lane merge
    // ------------------------------------------------------------
    function automatic logic [31:0] lane_merge(input logic [31:0] old, input logic [31:0] data,
                                               input logic [3:0] strb);
        logic [31:0] res;
        res = old;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                res[b*8 +: 8] = data[b*8 +: 8];
            end
        end
        return res;
    endfunction : lane_merge

    gcu_pin_sync u_sync (
        .clk_sys(clk_sys),
        .rst(rst),
        .pin_in(pin_in),
        .rise(rise),
        .fall(fall)
    );

    assign s_axi_awready = !st_reg.aw_got && !st_reg.bvalid;
    assign s_axi_wready = !st_reg.w_got && !st_reg.bvalid;
    assign s_axi_arready = !st_reg.rvalid;
    assign wr_go = st_reg.aw_got && st_reg.w_got && !st_reg.bvalid;

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        logic [1:0] rgn;
        logic [3:0] idx;
        logic [31:0] merged;
        int pr;
        rgn = st_reg.awaddr[gcu_pkg::GCU_RGN_MSB:gcu_pkg::GCU_RGN_LSB];
        idx = st_reg.awaddr[gcu_pkg::GCU_IDX_MSB:gcu_pkg::GCU_IDX_LSB];
        merged = '0;
        pr = 0;
        st_next = st_reg;
        st_next.irq = '0;
        if (s_axi_awvalid && s_axi_awready) begin
            st_next.aw_got = 1'b1;
            st_next.awaddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            st_next.w_got = 1'b1;
            st_next.wdata = s_axi_wdata;
            st_next.wstrb = s_axi_wstrb;
        end
        if (wr_go) begin
            st_next.aw_got = 1'b0;
            st_next.w_got = 1'b0;
            st_next.bvalid = 1'b1;
            st_next.bresp = (rgn == gcu_pkg::GCU_RGN_CTRL || rgn == gcu_pkg::GCU_RGN_VALUE) ?
                            gcu_pkg::GCU_RESP_OKAY : gcu_pkg::GCU_RESP_SLVERR;
        end
        if (st_reg.bvalid && s_axi_bready) begin
            st_next.bvalid = 1'b0;
        end
        if (s_axi_arvalid && s_axi_arready) begin
            st_next.rvalid = 1'b1;
            st_next.rresp = gcu_pkg::GCU_RESP_OKAY;
            st_next.rdata = '0;
            if (s_axi_araddr[gcu_pkg::GCU_RGN_MSB:gcu_pkg::GCU_RGN_LSB] == gcu_pkg::GCU_RGN_CTRL) begin
                st_next.rdata[gcu_pkg::GCU_CTRL_W-1:0] =
                    st_reg.ctrl[s_axi_araddr[gcu_pkg::GCU_IDX_MSB:gcu_pkg::GCU_IDX_LSB]];
            end else if (s_axi_araddr[gcu_pkg::GCU_RGN_MSB:gcu_pkg::GCU_RGN_LSB] == gcu_pkg::GCU_RGN_VALUE) begin
                st_next.rdata[gcu_pkg::GCU_TMR_W-1:0] =
                    st_reg.value[s_axi_araddr[gcu_pkg::GCU_IDX_MSB:gcu_pkg::GCU_IDX_LSB]];
            end else if (s_axi_araddr == gcu_pkg::GCU_PIN_OFF) begin
                st_next.rdata[gcu_pkg::GCU_CHANNELS-1:0] = st_reg.pin;
            end else begin
                st_next.rresp = gcu_pkg::GCU_RESP_SLVERR;
            end
        end
        if (st_reg.rvalid && s_axi_rready) begin
            st_next.rvalid = 1'b0;
        end
        for (int i = 0; i < gcu_pkg::GCU_CHANNELS; i++) begin
            cur_cnt[i] = st_reg.ctrl[i].tsel ? tmr_b.count : tmr_a.count;
            ovf[i] = st_reg.ctrl[i].tsel ? tmr_b.ovf : tmr_a.ovf;
            hit[i] = (st_reg.ctrl[i].tsel ? tmr_b.upd : tmr_a.upd) && cur_cnt[i] == st_reg.value[i];
            capt[i] = (st_reg.ctrl[i].edge_sel[gcu_pkg::GCU_EDGE_RISE_BIT] && rise[i]) ||
                      (st_reg.ctrl[i].edge_sel[gcu_pkg::GCU_EDGE_FALL_BIT] && fall[i]);
            wr_ctrl[i] = wr_go && rgn == gcu_pkg::GCU_RGN_CTRL && idx == 4'(i);
            // Software writes first, so a same-cycle hardware event wins
            if (wr_ctrl[i]) begin
                merged = lane_merge(32'(st_reg.ctrl[i]), st_reg.wdata, st_reg.wstrb);
                st_next.ctrl[i] = merged[gcu_pkg::GCU_CTRL_W-1:0] & gcu_pkg::GCU_CTRL_WMASK;
                st_next.fired[i] = 1'b0;
            end
            if (wr_go && rgn == gcu_pkg::GCU_RGN_VALUE && idx == 4'(i)) begin
                merged = lane_merge(32'(st_reg.value[i]), st_reg.wdata, st_reg.wstrb);
                st_next.value[i] = merged[gcu_pkg::GCU_TMR_W-1:0];
            end
            pr = i & ~1;
            unique case (st_reg.ctrl[i].mode)
                gcu_pkg::GCU_MODE_OFF: begin
                end
                gcu_pkg::GCU_MODE_CAPTURE: begin
                    if (capt[i]) begin
                        st_next.value[i] = cur_cnt[i];
                        st_next.irq[i] = 1'b1;
                    end
                end
                gcu_pkg::GCU_MODE_CMP_IRQ: begin
                    if (ovf[i]) begin
                        st_next.fired[i] = 1'b0;
                    end
                    if (hit[i] && !st_reg.fired[i] && !st_reg.ctrl[i].done) begin
                        st_next.irq[i] = 1'b1;
                        st_next.fired[i] = 1'b1;
                        st_next.ctrl[i].done = st_reg.ctrl[i].single;
                    end
                end
                gcu_pkg::GCU_MODE_CMP_SETCLR: begin
                    if (ovf[i]) begin
                        st_next.pin[i] = 1'b0;
                        st_next.fired[i] = 1'b0;
                        if (st_reg.pin[i] && st_reg.ctrl[i].single) begin
                            st_next.ctrl[i].done = 1'b1;
                        end
                    end
                    if (hit[i] && !st_reg.fired[i] && !st_reg.ctrl[i].done) begin
                        st_next.pin[i] = 1'b1;
                        st_next.irq[i] = 1'b1;
                        st_next.fired[i] = 1'b1;
                    end
                end
                gcu_pkg::GCU_MODE_DOUBLE: begin
                    // Two matches in one cycle cancel: net toggle is zero
                    if (hit[i] && !st_reg.ctrl[i].done) begin
                        st_next.pin[pr] = st_next.pin[pr] ^ 1'b1;
                        st_next.irq[i] = 1'b1;
                        st_next.ctrl[i].done = st_reg.ctrl[i].single;
                    end
                end
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    always_comb begin
        for (int i = 0; i < gcu_pkg::GCU_CHANNELS; i++) begin
            pin_oe[i] = st_reg.ctrl[i].mode == gcu_pkg::GCU_MODE_CMP_SETCLR ||
                        (st_reg.ctrl[i].mode == gcu_pkg::GCU_MODE_DOUBLE && (i % 2) == 0);
        end
    end
    assign pin_out = st_reg.pin;
    assign chan_irq = st_reg.irq;
    assign s_axi_bvalid = st_reg.bvalid;
    assign s_axi_bresp = st_reg.bresp;
    assign s_axi_rvalid = st_reg.rvalid;
    assign s_axi_rresp = st_reg.rresp;
    assign s_axi_rdata = st_reg.rdata;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    cap_value_a: assert property (@(posedge clk_sys) disable iff (rst)
        st_reg.ctrl[3].mode == gcu_pkg::GCU_MODE_CAPTURE && capt[3] |=> st_reg.value[3] == $past(cur_cnt[3]))
        else $error("capture did not latch the timer");
    cap_irq_a: assert property (@(posedge clk_sys) disable iff (rst)
        st_reg.ctrl[3].mode == gcu_pkg::GCU_MODE_CAPTURE && capt[3] |=> chan_irq[3])
        else $error("capture without interrupt");
    edge_select_a: assert property (@(posedge clk_sys) disable iff (rst)
        st_reg.ctrl[3].mode == gcu_pkg::GCU_MODE_CAPTURE && st_reg.ctrl[3].edge_sel == 2'h1 && fall[3]
        && !rise[3] && !wr_ctrl[3] |=> !chan_irq[3] && $stable(st_reg.value[3]))
        else $error("falling edge captured on rising selection");
    cmp_match_a: assert property (@(posedge clk_sys) disable iff (rst)
        st_reg.ctrl[5].mode == gcu_pkg::GCU_MODE_CMP_IRQ && hit[5] && !st_reg.fired[5]
        && !st_reg.ctrl[5].done |=> chan_irq[5] ##1 !chan_irq[5])
        else $error("compare match without action");
    irq_once_a: assert property (@(posedge clk_sys) disable iff (rst)
        st_reg.ctrl[5].mode == gcu_pkg::GCU_MODE_CMP_IRQ && st_reg.fired[5] && !ovf[5]
        && !wr_ctrl[5] |=> !chan_irq[5])
        else $error("second compare interrupt in one period");
    irq_pin_a: assert property (@(posedge clk_sys) disable iff (rst)
        st_reg.ctrl[5].mode == gcu_pkg::GCU_MODE_CMP_IRQ |-> !pin_oe[5])
        else $error("interrupt-only mode drives pin");
    setclr_set_a: assert property (@(posedge clk_sys) disable iff (rst)
        st_reg.ctrl[6].mode == gcu_pkg::GCU_MODE_CMP_SETCLR && hit[6] && !st_reg.fired[6]
        && !st_reg.ctrl[6].done |=> pin_out[6] && pin_oe[6])
        else $error("match did not set pin");
    setclr_clr_a: assert property (@(posedge clk_sys) disable iff (rst)
        st_reg.ctrl[6].mode == gcu_pkg::GCU_MODE_CMP_SETCLR && ovf[6] && !hit[6] |=> !pin_out[6])
        else $error("overflow did not clear pin");
    double_tog_a: assert property (@(posedge clk_sys) disable iff (rst)
        st_reg.ctrl[8].mode == gcu_pkg::GCU_MODE_DOUBLE && st_reg.ctrl[9].mode == gcu_pkg::GCU_MODE_DOUBLE
        && hit[9] && !hit[8] && !st_reg.ctrl[9].done |=> pin_out[8] != $past(pin_out[8]))
        else $error("odd register match did not toggle pair pin");
    single_stop_a: assert property (@(posedge clk_sys) disable iff (rst)
        st_reg.ctrl[10].mode == gcu_pkg::GCU_MODE_CMP_IRQ && st_reg.ctrl[10].done && !wr_ctrl[10]
        |=> $stable(pin_out[10]) && !chan_irq[10])
        else $error("action after single event finished");
endmodule : gcu_capcom

// ===== dv/gcu_pin_model.sv
// Outside pin partner of the capture/compare unit
`timescale 1ns/10ps
module gcu_pin_model (
    input wire logic clk_sys,
    input wire logic [gcu_pkg::GCU_CHANNELS-1:0] ext_level,
    input wire logic [gcu_pkg::GCU_CHANNELS-1:0] pin_out,
    input wire logic [gcu_pkg::GCU_CHANNELS-1:0] pin_oe,
    output logic [gcu_pkg::GCU_CHANNELS-1:0] pin_in
);
    logic [gcu_pkg::GCU_CHANNELS-1:0] drv_q = 16'h0000;
    // ----
    // Outside source
    // ----
    // Changes just after an edge of clk_sys, the clock that also samples the pin
    always @(posedge clk_sys) begin
        drv_q <= ext_level;
    end
    // Unit owns the wire while it drives
    assign pin_in = (pin_oe & pin_out) | (~pin_oe & drv_q);
endmodule : gcu_pin_model

// ===== dv/tb_top.sv
// Self-checking testbench of the capture/compare unit
`timescale 1ns/10ps
module tb_top;
    localparam logic [1:0] R_OK = gcu_pkg::GCU_RESP_OKAY;
    localparam logic [1:0] R_ERR = gcu_pkg::GCU_RESP_SLVERR;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata;
    gcu_pkg::gcu_timer_s tmr_a, tmr_b;
    logic [15:0] pin_in, pin_out, pin_oe, chan_irq;
    logic [15:0] ext_level = 16'h0000;
    logic [15:0] cnt = 16'h0000, tval = 16'h0000;
    logic trun = 1'b0, tstick = 1'b0, tload = 1'b0, pin8_q = 1'b0;
    int irq_cnt [16];
    int tog8 = 0;
    int n_mismatch = 0;
    int samples_checked = 0;
    // ----
    // Clock, timers, monitor
    // ----
    initial begin
        forever #2.5 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) begin
        if (tload) cnt <= tval;
        else if (trun && !tstick) cnt <= (cnt == 16'h001F) ? 16'h0000 : cnt + 16'h0001;
    end
    // Stuck mode keeps updating one count, to provoke repeated matches
    assign tmr_a = {cnt, trun, trun & ~tstick & (cnt == 16'h0000)};
    assign tmr_b = {cnt + 16'h0100, trun, trun & ~tstick & (cnt == 16'h0000)};
    always @(posedge clk_sys) begin
        for (int i = 0; i < 16; i++) if (chan_irq[i] === 1'b1) irq_cnt[i]++;
        if (pin_out[8] !== pin8_q) tog8++;
        pin8_q <= pin_out[8];
    end
    gcu_capcom gcu_capcom_i (.clk_sys, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .tmr_a, .tmr_b,
        .pin_in, .pin_out, .pin_oe, .chan_irq);
    gcu_pin_model gcu_pin_model_i (.clk_sys, .ext_level, .pin_out, .pin_oe, .pin_in);
    // ----
    // Shared tasks
    // ----
    task automatic end_sim();
        $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : end_sim
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic timed_out(input int n);
        if (n >= 100) begin
            chk(32'h0, 32'h1);
            end_sim();
        end
    endtask : timed_out
    task automatic axi_write(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        int n;
        n = 0;
        @(posedge clk_sys);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge clk_sys);
            n++;
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1 && n < 100);
        s_axi_bready <= 1'b0;
        timed_out(n);
        chk(32'(s_axi_bresp), 32'(er));
    endtask : axi_write
    task automatic axi_read(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
        int n;
        n = 0;
        @(posedge clk_sys);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge clk_sys);
            n++;
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1 && n < 100);
        s_axi_rready <= 1'b0;
        timed_out(n);
        chk(s_axi_rdata, ed);
        chk(32'(s_axi_rresp), 32'(er));
    endtask : axi_read
    task automatic set_tmr(input logic [15:0] v, input logic run, input logic stick);
        @(posedge clk_sys);
        tval <= v;
        tload <= 1'b1;
        trun <= 1'b0;
        @(posedge clk_sys);
        tload <= 1'b0;
        trun <= run;
        tstick <= stick;
    endtask : set_tmr
    task automatic wait_cnt(input logic [15:0] v);
        int n;
        n = 0;
        do begin
            @(posedge clk_sys);
            n++;
        end while (cnt !== v && n < 100);
        timed_out(n);
    endtask : wait_cnt
    // ----
    // Scenarios
    // ----
    task automatic t_regs();
        axi_read(8'h3C, 32'h0, R_OK);
        axi_write(8'h3C, 32'h000000FF, R_OK);
        axi_read(8'h3C, 32'h0000007F, R_OK);
        axi_write(8'h7C, 32'h0001ABCD, R_OK);
        axi_read(8'h7C, 32'h0000ABCD, R_OK);
        axi_write(8'h80, 32'h0000FFFF, R_ERR);
        axi_read(8'h80, 32'h0, R_OK);
        axi_read(8'hC0, 32'h0, R_ERR);
        axi_write(8'h3C, 32'h0, R_OK);
    endtask : t_regs
    task automatic t_capture();
        for (int es = 1; es < 4; es++) begin
            logic [31:0] c;
            int b;
            c = 32'h1 | (32'(es) << 3) | ((es == 3) ? 32'h20 : 32'h0);
            set_tmr(16'h1234, 1'b0, 1'b0);
            axi_write(8'h0C, c, R_OK);
            b = irq_cnt[3];
            @(posedge clk_sys);
            ext_level <= 16'h0008;
            repeat (10) @(posedge clk_sys);
            ext_level <= 16'h0000;
            repeat (10) @(posedge clk_sys);
            chk(32'(irq_cnt[3] - b), 32'(es[0]) + 32'(es[1]));
            axi_read(8'h4C, (es == 3) ? 32'h1334 : 32'h1234, R_OK);
        end
    endtask : t_capture
    task automatic t_mode2();
        int b;
        axi_write(8'h54, 32'h7, R_OK);
        set_tmr(16'h0007, 1'b1, 1'b1);
        b = irq_cnt[5];
        axi_write(8'h14, 32'h2, R_OK);
        repeat (20) @(posedge clk_sys);
        chk(32'(irq_cnt[5] - b), 32'h1);
        b = irq_cnt[5];
        set_tmr(16'h0008, 1'b1, 1'b0);
        repeat (80) @(posedge clk_sys);
        chk(32'(irq_cnt[5] - b), 32'h2);
        chk(32'({pin_oe[5], pin_out[5]}), 32'h0);
        set_tmr(16'h0000, 1'b0, 1'b0);
    endtask : t_mode2
    task automatic t_mode3();
        int b;
        axi_write(8'h58, 32'hA, R_OK);
        axi_write(8'h18, 32'h3, R_OK);
        b = irq_cnt[6];
        set_tmr(16'h0000, 1'b1, 1'b0);
        wait_cnt(16'h0014);
        chk(32'({pin_oe[6], pin_out[6]}), 32'h3);
        wait_cnt(16'h0005);
        chk(32'(pin_out[6]), 32'h0);
        wait_cnt(16'h0014);
        // Repeated matches after the set must stay silent
        set_tmr(16'h000A, 1'b1, 1'b1);
        repeat (10) @(posedge clk_sys);
        chk(32'(irq_cnt[6] - b), 32'h2);
        set_tmr(16'h0000, 1'b0, 1'b0);
        axi_read(8'h80, 32'h40, R_OK);
    endtask : t_mode3
    task automatic t_double();
        int b;
        axi_write(8'h60, 32'h4, R_OK);
        axi_write(8'h64, 32'h14, R_OK);
        axi_write(8'h20, 32'h4, R_OK);
        axi_write(8'h24, 32'h4, R_OK);
        b = tog8;
        set_tmr(16'h0000, 1'b1, 1'b0);
        wait_cnt(16'h000C);
        chk(32'(pin_out[8]), 32'h1);
        chk(32'(pin_oe[9:8]), 32'h1);
        wait_cnt(16'h0019);
        chk(32'(pin_out[8]), 32'h0);
        wait_cnt(16'h000C);
        wait_cnt(16'h0019);
        chk(32'(tog8 - b), 32'h4);
        set_tmr(16'h0000, 1'b0, 1'b0);
    endtask : t_double
    task automatic t_single();
        int b;
        axi_write(8'h68, 32'h3, R_OK);
        axi_write(8'h28, 32'h42, R_OK);
        b = irq_cnt[10];
        set_tmr(16'h0000, 1'b1, 1'b0);
        repeat (100) @(posedge clk_sys);
        set_tmr(16'h0000, 1'b0, 1'b0);
        chk(32'(irq_cnt[10] - b), 32'h1);
        axi_read(8'h28, 32'hC2, R_OK);
        axi_write(8'h28, 32'h42, R_OK);
        axi_read(8'h28, 32'h42, R_OK);
    endtask : t_single
    initial begin
        repeat (20) @(posedge clk_sys);
        rst <= 1'b0;
        t_regs();
        t_capture();
        t_mode2();
        t_mode3();
        t_double();
        t_single();
        end_sim();
    end
endmodule : tb_top
